//--- rtl/esi_pkg.sv
/*
  constants, offsets and state codes of the extended stack instruction unit.
  assumes a core that presents one instruction word per four-phase cycle.
*/
package esi_pkg;
  // extended opcodes, tested only while the extension is on; the second-word prefix is tested always
  localparam logic [15:0] OP_CALL_VIA_WORKING_REG = 16'h0014;
  localparam logic [7:0] OP_MOVE = 8'heb;
  localparam logic [7:0] OP_PUSH = 8'hea;
  localparam logic [7:0] OP_SUB = 8'he9;
  localparam logic [3:0] PFX_SECOND = 4'hf;
  localparam logic [1:0] SEL_RETURN = 2'h3;
  localparam logic [1:0] SP_INDEX = 2'h2;
  // standard opcode groups that carry an access bit
  localparam logic [3:0] OPG_FIRST = 4'h1;
  localparam logic [3:0] OPG_LAST = 4'hb;
  localparam logic [5:0] OPG_DEC = 6'h01;
  localparam logic [6:0] OPG_MUL = 7'h01;
  localparam int ACC_BIT = 8;
  localparam int IDX_BIT = 7;
  // access bank split and indexed threshold
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  localparam logic [3:0] ACC_HIGH_BANK = 4'hf;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [11:0] SP_STEP = 12'h001;
  localparam logic [11:0] PTR_RESET = 12'h000;
  localparam logic CTRL_RESET = 1'b0;
  // instruction phases, one system clock each
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PTR0 = 8'h04;
  localparam logic [7:0] OFS_PTR1 = 8'h08;
  localparam logic [7:0] OFS_PTR2 = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam int CTRL_EXT_BIT = 0;
  localparam int STAT_PHASE_LSB = 4;
  localparam int STAT_EXT_BIT = 8;
  localparam int STAT_NOP_BIT = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_FIRST = 3'b001,
    ST_MOVE2 = 3'b010,
    ST_FLUSH = 3'b100
  } esi_state_t;
endpackage

//--- rtl/esi_unit.sv
/*
  extended stack instruction unit: decode and execution of the stack
  extension opcodes and operand resolution for standard instructions,
  with an axi4-lite register slave.
  assumes the core holds instrWord and instrPc for a whole cycle, returns
  dataRd in the clock where memRe is high, and owns the real data memory.
*/
// Contract
// - indirect call pushes pc+2, loads pc
// - indirect call leaves working, flags, bank
// - indirect call: one word, two cycles
// - absolute move: source is pointer plus offset
// - absolute destination field is twelve bits
// - indirect source register reads as zero
// - indexed move: both addresses pointer-relative
// - indirect indexed destination makes no-op
// - moves: two words, write last phase
// - push writes literal, decrements pointer
// - subtract literal from chosen pointer
// - selector three means subtract and return
// - subtract-return pops pc, two cycles
// - extension enables indexed operand mode
// - extension off: access or bank select
// - low operands offset from stack pointer
// - applies to all access-bit instructions
// - zero pointer gives original mapping
// - config bit enables, defaults off
// - high operands keep absolute meaning
`timescale 1ns/100ps
module esi_unit #(
  parameter int AddrW = 8,
  parameter logic [11:0] IndMask = 12'hff8,
  parameter logic [11:0] IndMatch = 12'hfe8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] instrWord,
  input wire logic [20:0] instrPc,
  input wire logic [7:0] workingReg,
  input wire logic [7:0] pcHighLatch,
  input wire logic [4:0] pcUpperLatch,
  input wire logic [20:0] returnTop,
  input wire logic [3:0] bankSelect,
  input wire logic [7:0] dataRd,
  output logic pcLoad,
  output logic [20:0] pcLoadAddr,
  output logic retPush,
  output logic [20:0] retPushAddr,
  output logic retPop,
  output logic [11:0] memAddr,
  output logic memRe,
  output logic memWe,
  output logic [7:0] memWdata,
  output logic [11:0] operandAddr,
  output logic operandValid,
  output logic nopCycle,
  input wire logic [AddrW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AddrW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  initial begin
    if (AddrW < 8) begin
      $error("AddrW must hold the register offsets");
    end
  end

  // indirect-addressing register window
  function automatic logic isIndirect(input logic [11:0] a);
    isIndirect = (a & IndMask) == IndMatch;
  endfunction

  // byte-lane merge of a register write
  function automatic logic [31:0] mergeLanes(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    mergeLanes = res;
  endfunction

  // offset match against a register
  function automatic logic hitOfs(input logic [AddrW-1:0] a, input logic [7:0] ofs);
    hitOfs = a == AddrW'(ofs);
  endfunction

  // byte and bit instructions that carry an access bit
  function automatic logic hasAccessBit(input logic [15:0] w);
    hasAccessBit = (w[15:12] >= esi_pkg::OPG_FIRST && w[15:12] <= esi_pkg::OPG_LAST) ||
        w[15:10] == esi_pkg::OPG_DEC || w[15:9] == esi_pkg::OPG_MUL;
  endfunction

  esi_pkg::esi_state_t stateReg;
  logic [1:0] qReg;
  logic [15:0] irReg;
  logic [20:0] pcCap;
  logic [11:0] ptrReg [3];
  logic extEnable;
  logic moveIdxReg;
  logic srcIndReg;
  logic [7:0] srcData;
  logic awHeld, wHeld;
  logic [AddrW-1:0] awAddrReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;

  logic [11:0] spReg;
  logic inFirst, atQ2, atQ3, atQ4;
  logic isCall, isMove, isPush, isSub, isSubRet, isSecondWord;
  logic [1:0] subIdx;
  logic [11:0] srcAddr, destAddr;
  logic ptrBusy, wrFire, wrPtrHit, wrOk;
  logic [1:0] wrPtrIdx;
  logic [31:0] rdNext;
  logic [31:0] ptrMerged;
  logic [1:0] rdResp;

  assign spReg = ptrReg[esi_pkg::SP_INDEX];
  assign inFirst = stateReg == esi_pkg::ST_FIRST;
  assign atQ2 = qReg == esi_pkg::Q2;
  assign atQ3 = qReg == esi_pkg::Q3;
  assign atQ4 = qReg == esi_pkg::Q4;

  // decode of the captured word; every extended op is gated by the config bit
  // config bit gating
  assign isCall = extEnable && irReg == esi_pkg::OP_CALL_VIA_WORKING_REG;
  assign isMove = extEnable && irReg[15:8] == esi_pkg::OP_MOVE;
  assign isPush = extEnable && irReg[15:8] == esi_pkg::OP_PUSH;
  assign isSub = extEnable && irReg[15:8] == esi_pkg::OP_SUB;
  assign isSubRet = isSub && irReg[7:6] == esi_pkg::SEL_RETURN;
  assign subIdx = isSubRet ? esi_pkg::SP_INDEX : irReg[7:6];
  assign isSecondWord = irReg[15:12] == esi_pkg::PFX_SECOND;
  assign srcAddr = spReg + {5'h00, irReg[6:0]};
  // second word: absolute 12-bit field or pointer plus offset
  // twelve-bit destination
  assign destAddr = moveIdxReg ? spReg + {5'h00, irReg[6:0]} : irReg[11:0];
  assign ptrBusy = inFirst && atQ4 && (isPush || isSub);

  // phase counter: each system clock is one quarter of an instruction cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      qReg <= esi_pkg::Q1;
    end else begin
      qReg <= qReg + 2'h1;
    end
  end

  // instruction capture at the first phase of every cycle except a flush cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irReg <= 16'h0000;
      pcCap <= 21'h000000;
    end else if (qReg == esi_pkg::Q1 && stateReg != esi_pkg::ST_FLUSH) begin
      irReg <= instrWord;
      pcCap <= instrPc;
    end
  end

  // cycle sequencing; two-cycle ops leave for a second state at the last phase
  // call second cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stateReg <= esi_pkg::ST_FIRST;
      nopCycle <= 1'b0;
      moveIdxReg <= 1'b0;
      srcIndReg <= 1'b0;
    end else if (atQ4) begin
      unique case (stateReg)
        esi_pkg::ST_FIRST: begin
          if (isMove) begin
            stateReg <= esi_pkg::ST_MOVE2;
            moveIdxReg <= irReg[esi_pkg::IDX_BIT];
            srcIndReg <= isIndirect(srcAddr);
          end else if (isCall || isSubRet) begin
            stateReg <= esi_pkg::ST_FLUSH;
            nopCycle <= 1'b1;
          end
        end
        esi_pkg::ST_MOVE2: stateReg <= esi_pkg::ST_FIRST;
        esi_pkg::ST_FLUSH: begin
          stateReg <= esi_pkg::ST_FIRST;
          nopCycle <= 1'b0;
        end
      endcase
    end
  end

  // source byte of a move, caught while the read strobe is up
  // indirect source reads zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      srcData <= 8'h00;
    end else if (memRe) begin
      srcData <= srcIndReg ? 8'h00 : dataRd;
    end
  end

  // return stack and program counter requests; working reg, flags and bank stay untouched
  // push and target load
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      retPush <= 1'b0;
      retPushAddr <= 21'h000000;
      retPop <= 1'b0;
      pcLoad <= 1'b0;
      pcLoadAddr <= 21'h000000;
    end else begin
      retPush <= inFirst && atQ3 && isCall;
      retPop <= inFirst && atQ4 && isSubRet;
      pcLoad <= inFirst && atQ4 && (isCall || isSubRet);
      if (inFirst && atQ3 && isCall) begin
        retPushAddr <= pcCap + esi_pkg::PC_STEP;
      end
      if (inFirst && atQ4 && isCall) begin
        pcLoadAddr <= {pcUpperLatch, pcHighLatch, workingReg};
      end else if (inFirst && atQ4 && isSubRet) begin
        pcLoadAddr <= returnTop;
      end
    end
  end

  // data memory strobes: push and move read at the last phase, move write at the last phase of the next cycle
  // push write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      memAddr <= 12'h000;
      memRe <= 1'b0;
      memWe <= 1'b0;
      memWdata <= 8'h00;
    end else begin
      memRe <= 1'b0;
      memWe <= 1'b0;
      if (inFirst && atQ4 && isPush) begin
        memAddr <= spReg;
        memWdata <= irReg[7:0];
        memWe <= 1'b1;
      end else if (inFirst && atQ4 && isMove) begin
        memAddr <= srcAddr;
        memRe <= 1'b1;
      end else if (stateReg == esi_pkg::ST_MOVE2 && atQ4) begin
        memAddr <= destAddr;
        memWdata <= srcData;
        memWe <= !(moveIdxReg && isIndirect(destAddr));
      end
    end
  end

  // operand resolution of standard instructions, offered at the second phase
  // extension drives indexed mode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      operandAddr <= 12'h000;
      operandValid <= 1'b0;
    end else begin
      operandValid <= inFirst && atQ2 && hasAccessBit(irReg);
      if (inFirst && atQ2) begin
        if (irReg[esi_pkg::ACC_BIT]) begin
          operandAddr <= {bankSelect, irReg[7:0]};
        end else if (irReg[7:0] > esi_pkg::IDX_LIMIT) begin
          operandAddr <= {esi_pkg::ACC_HIGH_BANK, irReg[7:0]};
        end else if (extEnable) begin
          operandAddr <= spReg + {4'h0, irReg[7:0]};
        end else begin
          operandAddr <= {4'h0, irReg[7:0]};
        end
      end
    end
  end

  // pointer registers; core arithmetic blocks a bus write in the same clock
  // subtract from pointer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        ptrReg[i] <= esi_pkg::PTR_RESET;
      end
    end else if (inFirst && atQ4 && isPush) begin
      ptrReg[esi_pkg::SP_INDEX] <= spReg - esi_pkg::SP_STEP;
    end else if (inFirst && atQ4 && isSub) begin
      ptrReg[subIdx] <= ptrReg[subIdx] - {6'h00, irReg[5:0]};
    end else if (wrFire && wrPtrHit) begin
      ptrReg[wrPtrIdx] <= ptrMerged[11:0];
    end
  end

  // configuration bit, off after reset
  // extension default off
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      extEnable <= esi_pkg::CTRL_RESET;
    end else if (wrFire && hitOfs(awAddrReg, esi_pkg::OFS_CTRL) && wStrbReg[0]) begin
      extEnable <= wDataReg[esi_pkg::CTRL_EXT_BIT];
    end
  end

  // write decode
  always_comb begin
    wrPtrHit = 1'b1;
    wrPtrIdx = 2'h0;
    if (hitOfs(awAddrReg, esi_pkg::OFS_PTR1)) begin
      wrPtrIdx = 2'h1;
    end else if (hitOfs(awAddrReg, esi_pkg::OFS_PTR2)) begin
      wrPtrIdx = 2'h2;
    end else if (!hitOfs(awAddrReg, esi_pkg::OFS_PTR0)) begin
      wrPtrHit = 1'b0;
    end
    wrOk = wrPtrHit || hitOfs(awAddrReg, esi_pkg::OFS_CTRL);
  end
  assign wrFire = awHeld && wHeld && !s_axi_bvalid && !ptrBusy;
  // bus word merged over the current pointer; only the low twelve bits are kept
  assign ptrMerged = mergeLanes({20'h00000, ptrReg[wrPtrIdx]}, wDataReg, wStrbReg);

  // write channels taken in either order, answered once both are held
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= esi_pkg::RESP_OKAY;
      awAddrReg <= '0;
      wDataReg <= 32'h00000000;
      wStrbReg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddrReg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!awHeld && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!wHeld && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wrFire) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? esi_pkg::RESP_OKAY : esi_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read mux; status is read-only and shows the sequencer
  always_comb begin
    rdNext = 32'h00000000;
    rdResp = esi_pkg::RESP_OKAY;
    if (hitOfs(s_axi_araddr, esi_pkg::OFS_CTRL)) begin
      rdNext[esi_pkg::CTRL_EXT_BIT] = extEnable;
    end else if (hitOfs(s_axi_araddr, esi_pkg::OFS_PTR0)) begin
      rdNext[11:0] = ptrReg[0];
    end else if (hitOfs(s_axi_araddr, esi_pkg::OFS_PTR1)) begin
      rdNext[11:0] = ptrReg[1];
    end else if (hitOfs(s_axi_araddr, esi_pkg::OFS_PTR2)) begin
      rdNext[11:0] = ptrReg[2];
    end else if (hitOfs(s_axi_araddr, esi_pkg::OFS_STAT)) begin
      rdNext[2:0] = stateReg;
      rdNext[esi_pkg::STAT_PHASE_LSB +: 2] = qReg;
      rdNext[esi_pkg::STAT_EXT_BIT] = extEnable;
      rdNext[esi_pkg::STAT_NOP_BIT] = nopCycle;
    end else begin
      rdResp = esi_pkg::RESP_SLVERR;
    end
  end

  // read channel: answer one clock after the address is taken
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= esi_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdNext;
      s_axi_rresp <= rdResp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_call_push_addr: assert property (inFirst && atQ3 && isCall |=> retPush &&
      retPushAddr == $past(pcCap) + esi_pkg::PC_STEP) else $error("call pushed wrong return address");
  chk_call_target_load: assert property (inFirst && atQ4 && isCall |=> pcLoad &&
      pcLoadAddr == {$past(pcUpperLatch), $past(pcHighLatch), $past(workingReg)}) else $error("call target wrong");
  chk_flush_cycle_len: assert property ($rose(nopCycle) |-> nopCycle [*4] ##1 !nopCycle)
    else $error("no-op cycle not four phases");
  chk_push_write_dec: assert property (inFirst && atQ4 && isPush |=> memWe &&
      memAddr == $past(spReg) && spReg == $past(spReg) - esi_pkg::SP_STEP) else $error("push wrong");
  chk_move_src_addr: assert property (inFirst && atQ4 && isMove |=> memRe &&
      memAddr == $past(srcAddr) ##4 stateReg == esi_pkg::ST_FIRST) else $error("move source wrong");
  chk_move_dest_nop: assert property (stateReg == esi_pkg::ST_MOVE2 && atQ4 && moveIdxReg &&
      isIndirect(destAddr) |=> !memWe) else $error("indirect destination written");
  chk_src_zero_read: assert property (memRe && srcIndReg |=> srcData == 8'h00)
    else $error("indirect source not zero");
  chk_subret_pop_pc: assert property (inFirst && atQ4 && isSubRet |=> retPop && pcLoad &&
      pcLoadAddr == $past(returnTop) ##1 nopCycle) else $error("subtract-return wrong");
  chk_sub_sp_value: assert property (inFirst && atQ4 && isSub && subIdx == esi_pkg::SP_INDEX |=>
      spReg == $past(spReg) - {6'h00, $past(irReg[5:0])}) else $error("pointer subtract wrong");
  chk_operand_indexed: assert property (inFirst && atQ2 && extEnable && !irReg[esi_pkg::ACC_BIT] &&
      irReg[7:0] <= esi_pkg::IDX_LIMIT |=> operandAddr == $past(spReg) + {4'h0, $past(irReg[7:0])})
    else $error("indexed operand wrong");
  chk_ext_off_quiet: assert property (inFirst && atQ4 && !extEnable |=> !memWe && !memRe &&
      !pcLoad && !retPop) else $error("extended op ran while disabled");
  chk_stray_word_nop: assert property (inFirst && atQ4 && isSecondWord |=> !memWe && !memRe &&
      !pcLoad && !retPop) else $error("stray second word acted");

  cov_call: cover property (retPush ##1 pcLoad);
  cov_move_indexed: cover property (memRe && moveIdxReg ##4 memWe);
  cov_push: cover property (inFirst && atQ4 && isPush);
  cov_subret: cover property (retPop && pcLoad);
endmodule

//--- test/esi_unit_tb.sv
/*
  self-checking bench for esi_unit: reset and register bus checks, a table of
  instruction rows, then back-to-back and reset cases. assumes default parameters.
*/
`timescale 1ns/100ps
module testbench;
  typedef struct {
    logic ext;
    logic [11:0] sp;
    logic [15:0] w0, w1;
    logic [5:0] cnt;
    logic [11:0] weAddr;
    logic [7:0] weData;
    logic [20:0] aux;
    logic [11:0] spOut;
  } esi_row_t;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic [15:0] instrWord = 16'h0;
  logic [20:0] instrPc = 21'h1000;
  logic [7:0] workingReg = 8'h06;
  logic [7:0] pcHighLatch = 8'h10;
  logic [4:0] pcUpperLatch = 5'h0;
  logic [20:0] returnTop = 21'habcde;
  logic [3:0] bankSelect = 4'h3;
  logic [7:0] dataRd = 8'h5a;
  logic pcLoad, retPush, retPop, memRe, memWe, operandValid, nopCycle;
  logic [20:0] pcLoadAddr, retPushAddr, seenAux, seenPush;
  logic [11:0] memAddr, operandAddr, seenWeAddr;
  logic [7:0] memWdata, seenWeData;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [5:0] got;
  logic [6:0] evIn;
  int ev[7] = '{default: 0};
  int snap[7];
  int failures = 0;
  int comparisons = 0;
  // cnt bits: write, read, push, load, pop, operand
  // move destinations stay clear of pc and stack-top registers
  esi_row_t rows[25] = '{
    '{1'h1, 12'h100, 16'hea08, 16'h0, 6'h20, 12'h100, 8'h08, 21'h0, 12'h0ff},
    '{1'h1, 12'h000, 16'hea33, 16'h0, 6'h20, 12'h000, 8'h33, 21'h0, 12'hfff},
    '{1'h0, 12'h100, 16'hea08, 16'h0, 6'h00, 12'h0, 8'h0, 21'h0, 12'h100},
    '{1'h1, 12'h3ff, 16'he9a3, 16'h0, 6'h00, 12'h0, 8'h0, 21'h0, 12'h3dc},
    '{1'h1, 12'h010, 16'he9bf, 16'h0, 6'h00, 12'h0, 8'h0, 21'h0, 12'hfd1},
    '{1'h1, 12'h3ff, 16'he923, 16'h0, 6'h00, 12'h0, 8'h0, 21'h0, 12'h3ff},
    '{1'h1, 12'h3ff, 16'he9e3, 16'h0, 6'h06, 12'h0, 8'h0, 21'habcde, 12'h3dc},
    '{1'h1, 12'h200, 16'h0014, 16'h0, 6'h0c, 12'h0, 8'h0, 21'h1006, 12'h200},
    '{1'h1, 12'h080, 16'heb05, 16'hf123, 6'h30, 12'h123, 8'h5a, 21'h085, 12'h080},
    '{1'h1, 12'h080, 16'heb7f, 16'hffff, 6'h30, 12'hfff, 8'h5a, 21'h0ff, 12'h080},
    '{1'h1, 12'h080, 16'heb85, 16'hf006, 6'h30, 12'h086, 8'h5a, 21'h085, 12'h080},
    '{1'h1, 12'hfe0, 16'heb08, 16'hf200, 6'h30, 12'h200, 8'h00, 21'hfe8, 12'hfe0},
    '{1'h1, 12'hfe0, 16'heb81, 16'hf00a, 6'h10, 12'h0, 8'h0, 21'hfe1, 12'hfe0},
    '{1'h1, 12'ha00, 16'h2420, 16'h0, 6'h01, 12'h0, 8'h0, 21'ha20, 12'ha00},
    '{1'h1, 12'ha00, 16'h245f, 16'h0, 6'h01, 12'h0, 8'h0, 21'ha5f, 12'ha00},
    '{1'h1, 12'ha00, 16'h2460, 16'h0, 6'h01, 12'h0, 8'h0, 21'hf60, 12'ha00},
    '{1'h1, 12'ha00, 16'h2520, 16'h0, 6'h01, 12'h0, 8'h0, 21'h320, 12'ha00},
    '{1'h0, 12'ha00, 16'h2420, 16'h0, 6'h01, 12'h0, 8'h0, 21'h020, 12'ha00},
    '{1'h1, 12'h000, 16'h2430, 16'h0, 6'h01, 12'h0, 8'h0, 21'h030, 12'h000},
    '{1'h1, 12'ha00, 16'h8e10, 16'h0, 6'h01, 12'h0, 8'h0, 21'ha10, 12'ha00},
    '{1'h1, 12'ha00, 16'h0410, 16'h0, 6'h01, 12'h0, 8'h0, 21'ha10, 12'ha00},
    '{1'h1, 12'ha00, 16'h0210, 16'h0, 6'h01, 12'h0, 8'h0, 21'ha10, 12'ha00},
    '{1'h1, 12'ha00, 16'h0e10, 16'h0, 6'h00, 12'h0, 8'h0, 21'h0, 12'ha00},
    '{1'h0, 12'h200, 16'h0014, 16'h0, 6'h00, 12'h0, 8'h0, 21'h0, 12'h200},
    '{1'h1, 12'h100, 16'hf123, 16'h0, 6'h00, 12'h0, 8'h0, 21'h0, 12'h100}
  };

  esi_unit DUT (
    .sys_clk, .rst, .instrWord, .instrPc, .workingReg, .pcHighLatch, .pcUpperLatch, .returnTop,
    .bankSelect, .dataRd, .pcLoad, .pcLoadAddr, .retPush, .retPushAddr, .retPop, .memAddr, .memRe,
    .memWe, .memWdata, .operandAddr, .operandValid, .nopCycle, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  always #10 sys_clk = ~sys_clk;

  // event counters never clear, so snapshots avoid races with the recorder
  assign evIn = {nopCycle, memWe, memRe, retPush, pcLoad, retPop, operandValid};
  always @(posedge sys_clk) begin
    if (!rst) begin
      for (int k = 0; k < 7; k++) ev[k] <= ev[k] + evIn[k];
      if (memWe) begin
        seenWeAddr <= memAddr;
        seenWeData <= memWdata;
      end
      if (memRe) seenAux <= {9'h0, memAddr};
      if (pcLoad) seenAux <= pcLoadAddr;
      if (operandValid) seenAux <= {9'h0, operandAddr};
      if (retPush) seenPush <= retPushAddr;
    end
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // each channel released on its own handshake; a local flag ends the wait, since
  // the ready just dropped by a non-blocking assignment still reads high in this step
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    done = 1'b0;
    while (!done) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        done = 1'b1;
      end
    end
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    done = 1'b0;
    while (!done) begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        done = 1'b1;
      end
    end
  endtask

  task automatic setup(input logic ext, input logic [11:0] sp);
    axiWrite(esi_pkg::OFS_CTRL, {31'h0, ext}, resp);
    check(resp, esi_pkg::RESP_OKAY);
    axiWrite(esi_pkg::OFS_PTR2, {20'h0, sp}, resp);
  endtask

  // returns two edges after the sync word is taken, so a word set now is taken two edges later
  task automatic syncPhase();
    @(posedge sys_clk);
    instrWord <= 16'h2400;
    for (int i = 0; i < 12 && !operandValid; i++) @(posedge sys_clk);
  endtask

  task automatic issue(input logic [15:0] w);
    instrWord <= w;
    repeat (4) @(posedge sys_clk);
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    check({pcLoad, memWe, retPush, operandValid}, 4'h0);
    rst <= 1'h0;
    axiRead(esi_pkg::OFS_CTRL, rd, resp);
    check(rd, 32'h0);
    axiRead(esi_pkg::OFS_STAT, rd, resp);
    check(rd & 32'h307, 32'h001);
    axiRead(8'h14, rd, resp);
    check({resp, rd}, {esi_pkg::RESP_SLVERR, 32'h0});
    axiWrite(esi_pkg::OFS_STAT, 32'h1, resp);
    check(resp, esi_pkg::RESP_SLVERR);
    foreach (rows[n]) begin
      setup(rows[n].ext, rows[n].sp);
      syncPhase();
      issue(rows[n].w0);
      snap = ev;
      issue(rows[n].w1);
      issue(16'h0);
      issue(16'h0);
      for (int k = 0; k < 6; k++) got[k] = ev[k] != snap[k];
      check(got, rows[n].cnt);
      check(ev[6] - snap[6], rows[n].cnt[2] ? 4 : 0);
      if (rows[n].cnt[5]) check({seenWeAddr, seenWeData}, {rows[n].weAddr, rows[n].weData});
      if (rows[n].cnt & 6'h15) check(seenAux, rows[n].aux);
      if (rows[n].cnt[3]) check(seenPush, instrPc + 21'h2);
      axiRead(esi_pkg::OFS_PTR2, rd, resp);
      check(rd, {20'h0, rows[n].spOut});
    end
    setup(1'h1, 12'h100);
    syncPhase();
    issue(16'hea11);
    snap = ev;
    issue(16'hea22);
    issue(16'h0);
    check(ev[5] - snap[5], 2);
    check({seenWeAddr, seenWeData}, {12'h0ff, 8'h22});
    axiRead(esi_pkg::OFS_PTR2, rd, resp);
    check(rd, 32'h0fe);
    instrWord <= 16'hea55;
    repeat (6) @(posedge sys_clk);
    rst <= 1'h1;
    repeat (3) @(posedge sys_clk);
    check({memWe, memRe, pcLoad, operandValid}, 4'h0);
    rst <= 1'h0;
    axiRead(esi_pkg::OFS_CTRL, rd, resp);
    check(rd, 32'h0);
    axiRead(esi_pkg::OFS_PTR2, rd, resp);
    check(rd, 32'h0);
    complete_run();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    complete_run();
  end
endmodule
